// ===== block_move_pkg.sv
// constants, encodings and state types shared by the block-move executor
// assumes one core clock domain; memory region and wait-state hints come from the core
package block_move_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CYC_W  = 24;
  localparam int unsigned CNT_W  = 17;
  localparam int unsigned WAIT_W = 4;

  // ----------------------------------------------------------------
  // opcode high bytes (bits 15:8); bit 7 selects indirect addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DD_KSRC = 8'ha8;
  localparam logic [7:0] OP_DD_KDST = 8'ha9;
  localparam logic [7:0] OP_DD_BSRC = 8'hac;
  localparam logic [7:0] OP_DD_BDST = 8'had;
  localparam logic [7:0] OP_DP      = 8'h57;
  localparam logic [7:0] OP_PD_K    = 8'ha5;
  localparam logic [7:0] OP_PD_B    = 8'ha4;
  localparam int unsigned IND_BIT   = 7;

  // ----------------------------------------------------------------
  // instruction lengths and pointer step
  // ----------------------------------------------------------------
  localparam logic [1:0]        WORDS_LONG  = 2'h2;
  localparam logic [1:0]        WORDS_SHORT = 2'h1;
  localparam logic [WORD_W-1:0] PTR_STEP    = 16'h0001;
  localparam logic [WORD_W-1:0] EXT_BASE    = 16'h8000;

  // ----------------------------------------------------------------
  // cycle figures
  // ----------------------------------------------------------------
  localparam logic [CYC_W-1:0] CYC_ONE       = 24'h000001;
  localparam logic [CYC_W-1:0] CYC_ONCHIP    = 24'h000002;
  localparam logic [CYC_W-1:0] CYC_DST_EXT   = 24'h000003;
  localparam logic [CYC_W-1:0] CYC_REP_BOTHX = 24'h000004;
  localparam logic [CYC_W-1:0] CYC_CODE_DSTX = 24'h000002;
  localparam logic [CYC_W-1:0] CYC_REP_CONFL = 24'h000002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {REG_DUAL = 2'h0, REG_SINGLE = 2'h1, REG_EXT = 2'h2} region_t;

  typedef enum logic [2:0] {
    K_DD_KSRC = 3'h0, K_DD_KDST = 3'h1, K_DD_BSRC = 3'h2, K_DD_BDST = 3'h3,
    K_DP      = 3'h4, K_PD_K    = 3'h5, K_PD_B    = 3'h6, K_BAD     = 3'h7
  } kind_t;

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1} state_t;

endpackage

// ===== block_move_execution.sv
// block-move executor: data-to-data, data-to-program and program-to-data moves
// assumes the core holds the instruction stable while i_instr_valid and o_instr_ready meet,
// that memories answer a read in the granted cycle, and that region hints describe the operands

// ------------------------------------------------------------------
// word fifo
// ------------------------------------------------------------------
module move_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 cnt;
    logic [AW-1:0]               rp;
    logic [AW-1:0]               wp;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;

  assign o_in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = i_in_data;
      d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop)
    begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule // move_fifo

// ------------------------------------------------------------------
// executor
// ------------------------------------------------------------------
module block_move_execution
  import block_move_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_instr_valid,
  output logic                   o_instr_ready,
  input  wire logic [WORD_W-1:0] i_instr,
  input  wire logic [WORD_W-1:0] i_instr_ext,
  input  wire logic              i_rpt_active,
  input  wire logic [WORD_W-1:0] i_rpt_count,
  input  wire logic [WORD_W-1:0] i_block_move_address_reg,
  input  wire logic [8:0]        i_data_page,
  input  wire logic [WORD_W-1:0] i_aux_addr,
  input  wire logic [WORD_W-1:0] i_aux_step,
  input  wire logic [WORD_W-1:0] i_pfc,
  input  wire logic [1:0]        i_src_region,
  input  wire logic [1:0]        i_dst_region,
  input  wire logic [1:0]        i_code_region,
  input  wire logic              i_same_src_dst,
  input  wire logic              i_same_src_code,
  input  wire logic              i_same_dst_code,
  input  wire logic [WAIT_W-1:0] i_src_wait,
  input  wire logic [WAIT_W-1:0] i_dst_wait,
  input  wire logic [WAIT_W-1:0] i_code_wait,
  output logic                   o_rd_req,
  input  wire logic              i_rd_gnt,
  input  wire logic [WORD_W-1:0] i_rd_data,
  output logic      [WORD_W-1:0] o_rd_addr,
  output logic                   o_rd_prog,
  output logic                   o_rd_ext,
  output logic                   o_wr_req,
  input  wire logic              i_wr_gnt,
  output logic      [WORD_W-1:0] o_wr_addr,
  output logic      [WORD_W-1:0] o_wr_data,
  output logic                   o_wr_prog,
  output logic                   o_wr_ext,
  output logic                   o_ar_modify,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_illegal,
  output logic      [1:0]        o_words,
  output logic                   o_irq_inhibit,
  output logic      [WORD_W-1:0] o_pfc,
  output logic      [CYC_W-1:0]  o_cycles
);

  typedef struct packed {
    state_t            st;
    kind_t             kind;
    logic              rep;
    logic              ind;
    logic              src_pfc;
    logic [CNT_W-1:0]  left_rd;
    logic [CNT_W-1:0]  left_wr;
    logic [WORD_W-1:0] rd_ptr;
    logic [WORD_W-1:0] wr_ptr;
    logic [WORD_W-1:0] rd_step;
    logic [WORD_W-1:0] wr_step;
    logic              rd_prog;
    logic              wr_prog;
    logic [WORD_W-1:0] prefetch_counter;
    logic [WORD_W-1:0] microcall_stack;
    logic [CYC_W-1:0]  cyc;
    logic [CYC_W-1:0]  target;
    logic [1:0]        words;
    logic              done;
    logic              illegal;
    logic              inhibit;
  } exec_t;

  exec_t q;
  exec_t d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // the indirect flag sits in the low byte, so the whole high byte must match
  function automatic kind_t decode(input logic [7:0] op);
    case (op)
      OP_DD_KSRC: decode = K_DD_KSRC;
      OP_DD_KDST: decode = K_DD_KDST;
      OP_DD_BSRC: decode = K_DD_BSRC;
      OP_DD_BDST: decode = K_DD_BDST;
      OP_DP:      decode = K_DP;
      OP_PD_K:    decode = K_PD_K;
      OP_PD_B:    decode = K_PD_B;
      default:    decode = K_BAD;
    endcase
  endfunction

  function automatic logic is_ext(input logic [WORD_W-1:0] a);
    is_ext = (a >= EXT_BASE);
  endfunction

  // total busy cycles from region hints; n is the word count
  function automatic logic [CYC_W-1:0] calc_cycles(
    input logic block_move_address_reg_form, input logic move_data_to_program, input logic rep, input logic [CNT_W-1:0] n,
    input region_t s, input region_t dr, input region_t c,
    input logic ssd, input logic ssc, input logic sdc,
    input logic [WAIT_W-1:0] ws, input logic [WAIT_W-1:0] wd, input logic [WAIT_W-1:0] wc);
    logic [CYC_W-1:0] nn;
    logic [CYC_W-1:0] t;
    logic             sx;
    logic             dx;
    nn = CYC_W'(n);
    sx = (s == REG_EXT);
    dx = (dr == REG_EXT);
    if (!rep)
    begin
      if (sx && dx)
        t = CYC_DST_EXT + CYC_W'(ws) + CYC_W'(wd);
      else if (dx)
        t = CYC_DST_EXT + CYC_W'(wd);
      else if (sx)
        t = CYC_ONCHIP + CYC_W'(ws);
      else
        t = CYC_ONCHIP;
      if (!dx && dr == REG_SINGLE && sdc)
        t = t + CYC_ONE;
    end
    else
    begin
      if (sx && dx)
        t = CYC_REP_BOTHX * nn - CYC_ONE + nn * CYC_W'(ws) + nn * CYC_W'(wd);
      else if (dx)
        t = CYC_ONCHIP * nn + CYC_ONE + nn * CYC_W'(wd);
      else if (sx)
        t = nn + CYC_ONE + nn * CYC_W'(ws);
      else if (ssd && s == REG_SINGLE && dr == REG_SINGLE)
        t = sdc ? CYC_ONCHIP * nn + CYC_ONE : CYC_ONCHIP * nn - CYC_ONE;
      else if (dr == REG_SINGLE && sdc)
        t = nn + CYC_ONE + CYC_REP_CONFL;
      else
        t = nn + CYC_ONE;
    end
    if (move_data_to_program && ssc && s == REG_SINGLE)
      t = t + CYC_ONE;
    if (block_move_address_reg_form)
      t = t + CYC_ONE;
    if (c == REG_EXT)
      t = t + (block_move_address_reg_form ? CYC_ONCHIP * CYC_W'(wc) : CYC_W'(wc)) + (dx ? CYC_CODE_DSTX : '0);
    calc_cycles = t;
  endfunction

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  logic              rd_fire;
  logic              wr_fire;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  move_fifo #(.WIDTH(WORD_W), .DEPTH(4)) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (rd_fire),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_rd_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_wr_gnt),
    .o_out_data  (fifo_out_data)
  );

  // a full fifo stalls the reads, so a slow destination throttles the source
  assign o_rd_req      = (q.st == ST_RUN) && (q.left_rd != '0) && fifo_in_ready;
  assign rd_fire       = o_rd_req && i_rd_gnt;
  assign o_wr_req      = fifo_out_valid;
  assign wr_fire       = o_wr_req && i_wr_gnt;
  assign o_rd_addr     = q.rd_ptr;
  assign o_wr_addr     = q.wr_ptr;
  assign o_wr_data     = fifo_out_data;
  assign o_rd_prog     = q.rd_prog;
  assign o_wr_prog     = q.wr_prog;
  assign o_rd_ext      = is_ext(q.rd_ptr);
  assign o_wr_ext      = is_ext(q.wr_ptr);
  assign o_ar_modify   = q.ind && (q.src_pfc ? wr_fire : rd_fire);
  assign o_instr_ready = (q.st == ST_IDLE);
  assign o_busy        = (q.st == ST_RUN);
  assign o_done        = q.done;
  assign o_illegal     = q.illegal;
  assign o_words       = q.words;
  assign o_irq_inhibit = q.inhibit;
  assign o_pfc         = q.prefetch_counter;
  assign o_cycles      = q.target;

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_comb
  begin
    kind_t             k;
    logic              longf;
    logic              ind;
    logic [WORD_W-1:0] opnd;
    logic [WORD_W-1:0] ostep;
    logic [WORD_W-1:0] kval;
    logic              spfc;
    logic [CNT_W-1:0]  n;
    logic [CNT_W-1:0]  left_after;
    k          = decode(i_instr[15:8]);
    longf      = (k == K_DD_KSRC) || (k == K_DD_KDST) || (k == K_PD_K);
    ind        = i_instr[IND_BIT];
    opnd       = ind ? i_aux_addr : {i_data_page, i_instr[6:0]};
    ostep      = ind ? i_aux_step : '0;
    kval       = longf ? i_instr_ext : i_block_move_address_reg;
    spfc       = (k == K_DD_KSRC) || (k == K_DD_BSRC) || (k == K_PD_K) || (k == K_PD_B);
    n          = i_rpt_active ? CNT_W'(i_rpt_count) + CNT_W'(1) : CNT_W'(1);
    left_after = q.left_wr - CNT_W'(wr_fire);
    d          = q;
    d.done     = 1'b0;
    d.illegal  = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        if (i_instr_valid)
        begin
          if (k == K_BAD)
            d.illegal = 1'b1;
          else
          begin
            d.st      = ST_RUN;
            d.kind    = k;
            d.rep     = i_rpt_active;
            d.ind     = ind;
            d.src_pfc = spfc;
            d.rd_ptr  = spfc ? kval : opnd;
            d.rd_step = spfc ? PTR_STEP : ostep;
            d.wr_ptr  = spfc ? opnd : kval;
            d.wr_step = spfc ? ostep : PTR_STEP;
            d.rd_prog = (k == K_PD_K) || (k == K_PD_B);
            d.wr_prog = (k == K_DP);
            d.microcall_stack     = i_pfc;
            d.prefetch_counter     = kval;
            d.words   = longf ? WORDS_LONG : WORDS_SHORT;
            d.left_rd = n;
            d.left_wr = n;
            d.cyc     = '0;
            d.inhibit = i_rpt_active;
            d.target  = calc_cycles(!longf && (k != K_DP), k == K_DP, i_rpt_active, n,
                                    region_t'(i_src_region), region_t'(i_dst_region),
                                    region_t'(i_code_region), i_same_src_dst,
                                    i_same_src_code, i_same_dst_code,
                                    i_src_wait, i_dst_wait, i_code_wait);
          end
        end
      end
      ST_RUN:
      begin
        d.cyc = q.cyc + CYC_ONE;
        if (rd_fire)
        begin
          d.rd_ptr  = q.rd_ptr + q.rd_step;
          d.left_rd = q.left_rd - CNT_W'(1);
          if (q.src_pfc)
            d.prefetch_counter = q.prefetch_counter + PTR_STEP;
        end
        if (wr_fire)
        begin
          d.wr_ptr  = q.wr_ptr + q.wr_step;
          d.left_wr = left_after;
          if (!q.src_pfc)
            d.prefetch_counter = q.prefetch_counter + PTR_STEP;
        end
        if ((left_after == '0) && (q.cyc + CYC_ONE >= q.target))
        begin
          d.st      = ST_IDLE;
          d.done    = 1'b1;
          d.prefetch_counter     = q.microcall_stack;
          d.inhibit = 1'b0;
        end
      end
      default:
        d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  logic start;
  assign start = o_instr_ready && i_instr_valid && (decode(i_instr[15:8]) != K_BAD);

  sequence s_start_long;
    start && (decode(i_instr[15:8]) inside {K_DD_KSRC, K_DD_KDST, K_PD_K});
  endsequence

  sequence s_start_short;
    start && (decode(i_instr[15:8]) inside {K_DD_BSRC, K_DD_BDST, K_PD_B, K_DP});
  endsequence

  property p_long_words;
    s_start_long |=> (o_words == WORDS_LONG);
  endproperty
  a_long_words: assert property (p_long_words) else $error("long form not two words");

  property p_short_words;
    s_start_short |=> (o_words == WORDS_SHORT);
  endproperty
  a_short_words: assert property (p_short_words) else $error("short form not one word");

  property p_single_dual;
    s_start_long and (!i_rpt_active && i_src_region == REG_DUAL &&
      i_dst_region == REG_DUAL && i_code_region != REG_EXT) |=> (o_cycles == CYC_ONCHIP);
  endproperty
  a_single_dual: assert property (p_single_dual) else $error("single move not 2 cycles");

  property p_count;
    start && i_rpt_active |=> (q.left_wr == $past(i_rpt_count) + 17'h00001);
  endproperty
  a_count: assert property (p_count) else $error("word count not counter plus one");

  property p_inhibit;
    o_busy && q.rep |-> o_irq_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("interrupts not held off");

  property p_done_time;
    o_done |-> ($past(q.cyc) + CYC_ONE >= $past(q.target)) && !o_busy;
  endproperty
  a_done_time: assert property (p_done_time) else $error("move ended too early");

  property p_pfc_step;
    rd_fire && q.src_pfc && !(q.left_wr == 17'h00001 && wr_fire) |=>
      (o_pfc == $past(o_pfc) + PTR_STEP);
  endproperty
  a_pfc_step: assert property (p_pfc_step) else $error("source pointer did not advance");

  property p_direct_fixed;
    rd_fire && (q.rd_step == '0) |=> $stable(o_rd_addr);
  endproperty
  a_direct_fixed: assert property (p_direct_fixed) else $error("direct address moved");

  property p_restore;
    o_done |-> (o_pfc == q.microcall_stack);
  endproperty
  a_restore: assert property (p_restore) else $error("prefetch counter not restored");

  property p_refuse;
    o_instr_ready && i_instr_valid && (decode(i_instr[15:8]) == K_BAD) |=> o_illegal && !o_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad opcode not refused");

endmodule // block_move_execution

// ===== block_move_mem_model.sv
// far-side memory model: answers reads and takes writes for the block-move executor
// assumes the executor samples grants and read data on the rising core clock edge
module block_move_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slow,
  input  wire logic        i_rd_req,
  input  wire logic        i_rd_prog,
  input  wire logic [15:0] i_rd_addr,
  input  wire logic        i_wr_req,
  output logic             o_rd_gnt,
  output logic             o_wr_gnt,
  output logic      [15:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tog_q;
  logic [15:0] last_q;
  // slow mode grants reads and writes on alternate cycles, so the fifo never holds more than one word
  assign o_rd_gnt = i_rd_req & (~i_slow | tog_q);
  assign o_wr_gnt = i_wr_req & (~i_slow | ~tog_q);
  // outside a grant the bus shows a changing pattern, the inverse of the last word and that word in turn
  assign o_rd_data = o_rd_gnt ? (i_rd_addr ^ (i_rd_prog ? 16'ha5a5 : 16'h5a5a)) : ~last_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tog_q  <= 1'b0;
      last_q <= 16'h0000;
    end
    else
    begin
      tog_q  <= ~tog_q;
      last_q <= o_rd_data;
    end
  end
endmodule // block_move_mem_model

// ===== block_move_execution_tb_top.sv
// testbench for the block-move executor with the memory model on its far side
// assumes one core clock; inputs change 1 ns after the rising edge
module block_move_execution_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import block_move_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, repeat_prefix = 0, ssd = 0, ssc = 0, sdc = 0, slow = 0;
  logic [15:0] ins = 0, ext = 0, cnt = 0, block_move_address_reg = 16'h2800, aux = 16'h0310, prefetch_counter = 16'h0040;
  logic [8:0] page = 9'h006;
  logic [1:0] sr = 0, dr = 0, cr = 0;
  logic [3:0] ws = 0, wd = 0, wc = 0;
  logic rdy, rq, rg, rp, rx1, wq, wg, wp, wx, arm, busy, done, ill, irq;
  logic [15:0] rdat, ra1, wa1, wdat, opfc;
  logic [1:0] words;
  logic [CYC_W-1:0] cyc;
  int num_errors = 0, n_compared = 0, nb, na;
  logic [15:0] ra[$], wa[$], wv[$];
  logic rx[$];
  logic inh;

  block_move_execution dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_instr_valid(vld),
    .o_instr_ready(rdy), .i_instr(ins), .i_instr_ext(ext), .i_rpt_active(repeat_prefix),
    .i_rpt_count(cnt), .i_block_move_address_reg(block_move_address_reg), .i_data_page(page), .i_aux_addr(aux),
    .i_aux_step(16'h0001), .i_pfc(prefetch_counter), .i_src_region(sr), .i_dst_region(dr),
    .i_code_region(cr), .i_same_src_dst(ssd), .i_same_src_code(ssc), .i_same_dst_code(sdc),
    .i_src_wait(ws), .i_dst_wait(wd), .i_code_wait(wc), .o_rd_req(rq), .i_rd_gnt(rg),
    .i_rd_data(rdat), .o_rd_addr(ra1), .o_rd_prog(rp), .o_rd_ext(rx1), .o_wr_req(wq),
    .i_wr_gnt(wg), .o_wr_addr(wa1), .o_wr_data(wdat), .o_wr_prog(wp), .o_wr_ext(wx),
    .o_ar_modify(arm), .o_busy(busy), .o_done(done), .o_illegal(ill), .o_words(words),
    .o_irq_inhibit(irq), .o_pfc(opfc), .o_cycles(cyc));
  block_move_mem_model mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
    .i_rd_req(rq), .i_rd_prog(rp), .i_rd_addr(ra1), .i_wr_req(wq), .o_rd_gnt(rg),
    .o_wr_gnt(wg), .o_rd_data(rdat));

  initial forever #20 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  // issue one instruction and log every granted access until completion
  task automatic go(input logic [7:0] op, input logic [6:0] dm, input logic [15:0] k);
    ra = {};
    wa = {};
    wv = {};
    rx = {};
    nb = 0;
    na = 0;
    inh = 1'b1;
    @(posedge clk);
    #1 ins = {op, 1'b0, dm};
    ext = k;
    vld = 1'b1;
    @(posedge clk);
    #1 vld = 1'b0;
    for (int i = 0; i < 300 && done !== 1'b1; i++)
    begin
      @(negedge clk);
      if (rq === 1'b1 && rg === 1'b1)
      begin
        ra.push_back(ra1);
        rx.push_back(rx1);
      end
      if (wq === 1'b1 && wg === 1'b1)
      begin
        wa.push_back(wa1);
        wv.push_back(wdat);
        chk(wx === (wa1 >= EXT_BASE), "write routing");
      end
      if (arm === 1'b1)
        na++;
      if (busy === 1'b1)
      begin
        nb++;
        inh &= irq;
      end
    end
    if (done !== 1'b1)
    begin
      num_errors++;
      results();
    end
  endtask

  // cycle budget for one region setup; n is the repeat counter value
  task automatic cy(input logic [7:0] op, input logic [1:0] s, d, c, input logic [2:0] sm,
                    input logic [3:0] a, b, e, input logic [15:0] n, input int x);
    @(posedge clk);
    #1 sr = s;
    dr = d;
    cr = c;
    {ssd, ssc, sdc} = sm;
    ws = a;
    wd = b;
    wc = e;
    repeat_prefix = (n != 0);
    cnt = n;
    go(op, 7'h05, 16'h0300);
    chk(cyc === CYC_W'(x) && nb == x, "cycle count");
    chk(words === ((op == OP_DD_KSRC || op == OP_DD_KDST) ? WORDS_LONG : WORDS_SHORT), "length");
    chk(wa.size() == n + 1, "word count");
    chk(inh === repeat_prefix, "interrupt hold");
    $display("cycle test done, op %h", op);
  endtask

  // repeated move: source and destination address walk plus copied data
  task automatic dx(input logic [7:0] op, input logic [6:0] dm, input logic [15:0] k, rs,
                    input int rst, input logic [15:0] w0, input int wst, pat, n);
    @(posedge clk);
    #1 {sr, dr, cr, ssd, ssc, sdc, ws, wd, wc} = '0;
    repeat_prefix = 1'b1;
    cnt = 16'(n - 1);
    go(op, dm, k);
    chk(opfc === prefetch_counter, "prefetch restore");
    chk((words == WORDS_LONG) === (op inside {OP_PD_K, OP_DD_KSRC}), "len");
    chk(wp === (op == OP_DP) && rp === (op inside {OP_PD_K, OP_PD_B}), "space");
    chk(na == 0, "aux register untouched");
    chk(ra.size() == n && wa.size() == n, "word count");
    for (int i = 0; i < n && i < ra.size() && i < wa.size(); i++)
    begin
      chk(ra[i] === rs + 16'(i * rst), "source step");
      chk(rx[i] === (ra[i] >= EXT_BASE), "routing");
      chk(wa[i] === w0 + 16'(i * wst), "destination step");
      chk(wv[i] === (ra[i] ^ 16'(pat)), "data");
    end
    $display("transfer test done, op %h", op);
  endtask

  // the second opcode differs from a long-source move only in its top bit
  task automatic bad_op();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      #1 ins = (i == 0) ? 16'h0000 : 16'h2805;
      vld = 1'b1;
      @(posedge clk);
      #1 vld = 1'b0;
      @(negedge clk);
      chk(ill === 1'b1 && busy === 1'b0, "refusal");
    end
    $display("refusal test done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    cy(OP_DD_KSRC, 0, 0, 0, 3'b000, 0, 0, 0, 0, 2);
    cy(OP_DD_KSRC, 0, 0, 2, 3'b000, 0, 0, 2, 0, 4);
    cy(OP_DD_KDST, 0, 2, 0, 3'b000, 0, 3, 0, 0, 6);
    cy(OP_DD_KSRC, 2, 2, 0, 3'b000, 1, 2, 0, 1, 13);
    cy(OP_DD_KSRC, 0, 0, 0, 3'b000, 0, 0, 0, 2, 4);
    cy(OP_DD_KSRC, 1, 1, 0, 3'b100, 0, 0, 0, 3, 7);
    cy(OP_DD_KSRC, 1, 1, 1, 3'b111, 0, 0, 0, 3, 9);
    cy(OP_DD_BSRC, 0, 0, 0, 3'b000, 0, 0, 0, 0, 3);
    cy(OP_DD_BDST, 0, 0, 0, 3'b000, 0, 0, 0, 2, 5);
    cy(OP_DP, 1, 0, 1, 3'b010, 0, 0, 0, 1, 4);
    dx(OP_DD_KSRC, 7'h05, 16'h0300, 16'h0300, 1, 16'h0305, 0, 16'h5a5a, 3);
    slow = 1'b1;
    dx(OP_PD_K, 7'h05, 16'h7ffe, 16'h7ffe, 1, 16'h0305, 0, 16'ha5a5, 3);
    slow = 1'b0;
    dx(OP_PD_K, 7'h7f, 16'hffff, 16'hffff, 1, 16'h037f, 0, 16'ha5a5, 1);
    dx(OP_PD_B, 7'h05, 16'h0000, 16'h2800, 1, 16'h0305, 0, 16'ha5a5, 2);
    dx(OP_DP, 7'h05, 16'h0000, 16'h0305, 0, 16'h2800, 1, 16'h5a5a, 2);
    bad_op();
    results();
  end
endmodule // block_move_execution_tb_top
